// [src/pdc_pkg.sv]
// Purpose: Shared constants and types for the duplex and collision-test control block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Control word sits at offset 0, the status word at offset 4
`default_nettype none
package pdc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    // Field positions in the control word
    localparam int BIT_AN_EN = 12;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;
    localparam int RSV_HI = 6;
    // Field positions in the status word
    localparam int ST_FULL = 0;
    localparam int ST_COL = 1;
    // Reset values
    localparam logic RST_DUPLEX = 1'b1;
    localparam logic RST_COL_TEST = 1'b0;
    localparam logic RST_AN_EN = 1'b0;
    localparam logic [6:0] RST_RSV = 7'h00;

    // Whole state of the block
    typedef struct packed {
        logic an_en;
        logic duplex_sw;
        logic col_test;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic full_duplex;
        logic collision;
    } pdc_state_t;
endpackage : pdc_pkg
`default_nettype wire

// [src/pdc_ctrl.sv]
// Purpose: Duplex mode and collision-test control fields behind an APB slave
// Assumes: Negotiated duplex and transmit-active arrive synchronous to clock
// Notes: pready is registered, so every access phase holds exactly one wait state
// Function
// - Duplex is a read-write bit 8 that resets to 1, where 1 means full duplex and 0 half duplex.
// - A written duplex value takes effect only while auto-negotiation enable bit 12 is clear.
// - With auto-negotiation on, the duplex bit reports the negotiated duplex, not the written one.
// - Collision test is a read-write bit 7 that resets to 0, where 1 enables the test.
// - With collision test on in half duplex, collision is raised while a transmission is active.
// - Bits 6:0 are reserved, reset to zero, read as zero and have no function.
//
// The APB slave port and the placing of the registers were left to the implementer.
`default_nettype none
module pdc_ctrl (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic an_full_duplex,
    input wire logic tx_active,
    output logic full_duplex,
    output logic collision
);

    // Reset image of the whole state; the duplex in force starts as the written default
    localparam pdc_pkg::pdc_state_t RST_STATE = '{
        an_en: pdc_pkg::RST_AN_EN,
        duplex_sw: pdc_pkg::RST_DUPLEX,
        col_test: pdc_pkg::RST_COL_TEST,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0,
        full_duplex: pdc_pkg::RST_DUPLEX,
        collision: 1'b0
    };

    // Address decode of the control word
    function automatic logic hit_ctrl(input logic [7:0] addr);
        return addr == pdc_pkg::OFS_CTRL;
    endfunction : hit_ctrl

    // Address decode of the status word
    function automatic logic hit_stat(input logic [7:0] addr);
        return addr == pdc_pkg::OFS_STAT;
    endfunction : hit_stat

    // Duplex in force: negotiated while auto-negotiation runs, else the written one
    function automatic logic eff_duplex(
        input logic an_en,
        input logic sw,
        input logic an_fd
    );
        return an_en ? an_fd : sw;
    endfunction : eff_duplex

    // Read image of the control word; reserved bits always read as zero
    function automatic logic [31:0] ctrl_image(
        input pdc_pkg::pdc_state_t s,
        input logic an_fd
    );
        logic [31:0] w;
        w = '0;
        w[pdc_pkg::RSV_HI:0] = pdc_pkg::RST_RSV;
        w[pdc_pkg::BIT_AN_EN] = s.an_en;
        w[pdc_pkg::BIT_DUPLEX] = eff_duplex(s.an_en, s.duplex_sw, an_fd);
        w[pdc_pkg::BIT_COL_TEST] = s.col_test;
        return w;
    endfunction : ctrl_image

    // Read image of the status word
    function automatic logic [31:0] stat_image(input pdc_pkg::pdc_state_t s);
        logic [31:0] w;
        w = '0;
        w[pdc_pkg::ST_FULL] = s.full_duplex;
        w[pdc_pkg::ST_COL] = s.collision;
        return w;
    endfunction : stat_image

    // Registered state and its next value
    pdc_pkg::pdc_state_t state_ff;
    pdc_pkg::pdc_state_t nxt_state;

    // Bus phase decode and the duplex currently in force
    logic acc_phase;
    logic acc_done;
    logic hit_any;
    logic duplex_now;

    // First access cycle loads read data; the second, with pready high, completes
    assign acc_phase = psel && penable && !state_ff.pready;
    assign acc_done = psel && penable && state_ff.pready;
    assign hit_any = hit_ctrl(paddr) || hit_stat(paddr);
    assign duplex_now = eff_duplex(state_ff.an_en, state_ff.duplex_sw, an_full_duplex);

    // Next-state logic for bus answer, control fields and line outputs
    always_comb begin
        nxt_state = state_ff;
        // One wait state, then a single-cycle ready pulse
        nxt_state.pready = acc_phase;
        // Unmapped offsets answer with an error
        nxt_state.pslverr = acc_phase && !hit_any;
        // Read data is captured at the same edge that raises pready, so it stands at the sampling edge
        if (acc_phase && !pwrite) begin
            if (hit_ctrl(paddr)) begin
                nxt_state.prdata = ctrl_image(state_ff, an_full_duplex);
            end else if (hit_stat(paddr)) begin
                nxt_state.prdata = stat_image(state_ff);
            end else begin
                nxt_state.prdata = '0;
            end
        end
        // A write takes effect only at the edge where pready is seen high
        if (acc_done && pwrite && hit_ctrl(paddr)) begin
            nxt_state.an_en = pwdata[pdc_pkg::BIT_AN_EN];
            nxt_state.col_test = pwdata[pdc_pkg::BIT_COL_TEST];
            // Written duplex is kept only when auto-negotiation stays off
            if (!pwdata[pdc_pkg::BIT_AN_EN]) begin
                nxt_state.duplex_sw = pwdata[pdc_pkg::BIT_DUPLEX];
            end
        end
        // Reserved bits are never stored, so they carry no function
        nxt_state.full_duplex = duplex_now;
        // Forced collision only in half duplex while a packet goes out
        nxt_state.collision = state_ff.col_test && !duplex_now && tx_active;
    end

    // State register with asynchronous reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= RST_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign full_duplex = state_ff.full_duplex;
    assign collision = state_ff.collision;

    // Duplex write lands when the written word leaves auto-negotiation off
    property p_dup_write;
        @(posedge clock) disable iff (!arst_n)
        (acc_done && pwrite && hit_ctrl(paddr) && !pwdata[pdc_pkg::BIT_AN_EN])
        |=> (state_ff.duplex_sw == $past(pwdata[pdc_pkg::BIT_DUPLEX]));
    endproperty : p_dup_write
    a_dup_write: assert property (p_dup_write)
        else $error("duplex write was not applied");

    // Duplex write is ignored while auto-negotiation is on
    property p_dup_keep;
        @(posedge clock) disable iff (!arst_n)
        (acc_done && pwrite && hit_ctrl(paddr) && pwdata[pdc_pkg::BIT_AN_EN])
        |=> $stable(state_ff.duplex_sw);
    endproperty : p_dup_keep
    a_dup_keep: assert property (p_dup_keep)
        else $error("duplex changed with auto-negotiation on");

    // With auto-negotiation on, duplex follows the negotiated result
    property p_full_neg;
        @(posedge clock) disable iff (!arst_n)
        state_ff.an_en |=> (full_duplex == $past(an_full_duplex));
    endproperty : p_full_neg
    a_full_neg: assert property (p_full_neg)
        else $error("duplex does not follow negotiation");

    // With auto-negotiation off, duplex follows the written value
    property p_full_sw;
        @(posedge clock) disable iff (!arst_n)
        !state_ff.an_en |=> (full_duplex == $past(state_ff.duplex_sw));
    endproperty : p_full_sw
    a_full_sw: assert property (p_full_sw)
        else $error("duplex does not follow written value");

    // Collision-test field takes the written bit
    property p_col_write;
        @(posedge clock) disable iff (!arst_n)
        (acc_done && pwrite && hit_ctrl(paddr))
        |=> (state_ff.col_test == $past(pwdata[pdc_pkg::BIT_COL_TEST]));
    endproperty : p_col_write
    a_col_write: assert property (p_col_write)
        else $error("collision-test write was not applied");

    // Test on, half duplex and transmitting raises collision
    property p_coll_on;
        @(posedge clock) disable iff (!arst_n)
        (state_ff.col_test && tx_active
            && !(state_ff.an_en ? an_full_duplex : state_ff.duplex_sw))
        |=> collision;
    endproperty : p_coll_on
    a_coll_on: assert property (p_coll_on)
        else $error("collision missing during test");

    // No test, no transmit or full duplex keeps collision low
    property p_coll_off;
        @(posedge clock) disable iff (!arst_n)
        (!state_ff.col_test || !tx_active
            || (state_ff.an_en ? an_full_duplex : state_ff.duplex_sw))
        |=> !collision;
    endproperty : p_coll_off
    a_coll_off: assert property (p_coll_off)
        else $error("collision raised outside test");

    // Reserved bits of the control word read as zero
    property p_rsv_zero;
        @(posedge clock) disable iff (!arst_n)
        (acc_done && !pwrite && hit_ctrl(paddr))
        |-> (state_ff.prdata[pdc_pkg::RSV_HI:0] == pdc_pkg::RST_RSV);
    endproperty : p_rsv_zero
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bits read nonzero");

    // Main scenarios worth seeing
    c_an_write: cover property (@(posedge clock) disable iff (!arst_n)
        acc_done && pwrite && hit_ctrl(paddr) && pwdata[pdc_pkg::BIT_AN_EN]);
    c_coll_rise: cover property (@(posedge clock) disable iff (!arst_n)
        $rose(state_ff.collision));
    c_stat_read: cover property (@(posedge clock) disable iff (!arst_n)
        acc_done && !pwrite && hit_stat(paddr));
    c_bad_addr: cover property (@(posedge clock) disable iff (!arst_n)
        state_ff.pslverr);
endmodule : pdc_ctrl
`default_nettype wire

// [testbench/phy_duplex_collision_test_control_tb.sv]
// Purpose: Self-checking bench for the duplex and collision-test control block
// Assumes: Registered pready; every transfer waits for it at a rising edge
// Notes: Random stimulus from seed 40 with reset and bad-address corners
`default_nettype none
module phy_duplex_collision_test_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LIMIT = 20;

    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic an_full_duplex = 1'b0;
    logic tx_active = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic full_duplex;
    logic collision;
    logic [31:0] rd_q;
    logic err_q;
    logic sw_dup;
    logic exp_fd;
    logic [31:0] v;
    logic [31:0] seed_val;
    int failures = 0;
    int tests_run = 0;

    // Clock of 10 ns period
    always #5 clock = ~clock;

    pdc_ctrl u_pdc_ctrl (
        .clock(clock),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .an_full_duplex(an_full_duplex),
        .tx_active(tx_active),
        .full_duplex(full_duplex),
        .collision(collision)
    );

    // Final report and end of run
    task automatic give_verdict(input int extra);
        failures += extra;
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] expected);
        tests_run++;
        if (seen !== expected) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < LIMIT);
        if (pready !== 1'b1) begin
            give_verdict(1);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Expected duplex in force
    function automatic logic exp_full(input logic an, input logic sw, input logic anfd);
        return an ? anfd : sw;
    endfunction : exp_full

    // Expected control word image
    function automatic logic [31:0] exp_ctrl(
        input logic an,
        input logic sw,
        input logic col,
        input logic anfd
    );
        logic [31:0] w;
        w = '0;
        w[pdc_pkg::BIT_AN_EN] = an;
        w[pdc_pkg::BIT_DUPLEX] = exp_full(an, sw, anfd);
        w[pdc_pkg::BIT_COL_TEST] = col;
        return w;
    endfunction : exp_ctrl

    // Test sequence
    initial begin
        seed_val = $urandom(40);
        sw_dup = pdc_pkg::RST_DUPLEX;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values
        apb(1'b0, pdc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd_q, 32'h0000_0100);
        chk({31'h0, full_duplex}, {31'h0, pdc_pkg::RST_DUPLEX});
        // Unmapped offset answers with an error and zero data
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({31'h0, err_q}, 32'h0000_0001);
        chk(rd_q, 32'h0000_0000);
        repeat (40) begin
            v = $urandom & 32'h0000_1180;
            {an_full_duplex, tx_active} <= 2'($urandom);
            apb(1'b1, pdc_pkg::OFS_CTRL, v);
            if (!v[pdc_pkg::BIT_AN_EN]) begin
                sw_dup = v[pdc_pkg::BIT_DUPLEX];
            end
            apb(1'b0, pdc_pkg::OFS_CTRL, 32'h0000_0000);
            exp_fd = exp_full(v[pdc_pkg::BIT_AN_EN], sw_dup, an_full_duplex);
            chk({31'h0, err_q}, 32'h0000_0000);
            chk(rd_q, exp_ctrl(v[12], sw_dup, v[7], an_full_duplex));
            chk({31'h0, full_duplex}, {31'h0, exp_fd});
            chk({31'h0, collision}, {31'h0, v[7] & ~exp_fd & tx_active});
            apb(1'b0, pdc_pkg::OFS_STAT, 32'h0000_0000);
            chk(rd_q, {30'h0, v[7] & ~exp_fd & tx_active, exp_fd});
        end
        // Forced half duplex with test on and a transmission in progress
        an_full_duplex <= 1'b1;
        tx_active <= 1'b1;
        apb(1'b1, pdc_pkg::OFS_CTRL, 32'h0000_0080);
        sw_dup = 1'b0;
        apb(1'b0, pdc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd_q, 32'h0000_0080);
        chk({31'h0, collision}, 32'h0000_0001);
        // Reset in mid-run restores the defaults
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        sw_dup = pdc_pkg::RST_DUPLEX;
        apb(1'b0, pdc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd_q, 32'h0000_0100);
        chk({31'h0, collision}, 32'h0000_0000);
        give_verdict(0);
    end
endmodule : phy_duplex_collision_test_control_tb
`default_nettype wire
